// >>> pfc_fault_supervisor_consts.svh
/*
  Constants for the fault supervisor: register offsets, field positions,
  reset values and timing counts.
  Assumes a 125 MHz system clock and a 32-bit APB register bus.
*/
// Notes on behaviour
// - Power good high only in regulated operation
// - Power good low during supply lockout
// - Thermal, undervoltage, line or pin faults drop power good
// - Latch-off input forces shutdown and power good low
// - Start-up latch set on entry, blocks power good
// - Start-up latch clears when error amp stops charging
// - Too little timing pin current turns off
// - Line low enables hold clamp
// - First line low starts blanking, no fault meanwhile
// - Line low during detection window declares fault
// - Line high through whole window means no fault
// - Window end resets line latch and timers
// - Line fault stops drive, grounds control, drops good
// - Line fault resets timers, drops clamp, enables sink
// - Start in line fault, sink after lockout ends
// - Sink stays on until line input recovers
// - Thermal hysteresis between upper and lower limits
// - Reset selects the upper thermal threshold
// - Major faults turn off, recovery is automatic
// - Timing pin fault blanked before latching
// - Timing pin latch cleared during supply lockout
`ifndef PFC_FAULT_SUPERVISOR_CONSTS_SVH
`define PFC_FAULT_SUPERVISOR_CONSTS_SVH

// Clock and timing
`define CLK_MHZ 125
`define TICK_US 1000
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define BLANK_MS 500
`define WINDOW_MS 50
`define BLANK_TICKS (`BLANK_MS * 1000 / `TICK_US)
`define WINDOW_TICKS (`WINDOW_MS * 1000 / `TICK_US)
`define PIN_BLANK_US 30
`define PIN_BLANK_CYCLES (`PIN_BLANK_US * `CLK_MHZ)

// Register map, byte addresses
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004

// Control fields
`define CTRL_RUN_BIT 0
`define CTRL_PIN_CLR_BIT 1
`define CTRL_RESET 2'h1

`endif

// >>> pfc_fault_supervisor_pkg.sv
/*
  Types for the fault supervisor: bus request carrier, status word,
  brown-out states.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none

package pfc_fault_supervisor_pkg;

  // APB request from the master
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  // Live state shown in the status register
  typedef struct packed {
    logic startup_phase;
    logic line_low_latch;
    logic timing_pin_open;
    logic thermal_shutdown;
    logic line_fault_flag;
    logic supply_lockout;
    logic power_good;
  } status_t;

  // Brown-out qualifier states
  typedef enum logic [1:0] {
    BO_FAULT,
    BO_IDLE,
    BO_BLANK,
    BO_WINDOW
  } bo_state_t;

endpackage : pfc_fault_supervisor_pkg

`default_nettype wire

// >>> pfc_fault_supervisor.sv
/*
  Fault supervisor and power-good logic for an interleaved power-factor
  stage, with an APB slave for control and status.
  Assumes every comparator result arrives already synchronous to i_clk
  and that the analog side acts on the enables this block drives.
*/
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_fault_supervisor_consts.svh"

module pfc_fault_supervisor #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int BLANK_TICKS = `BLANK_TICKS,
  parameter int WINDOW_TICKS = `WINDOW_TICKS,
  parameter int PIN_BLANK_CYCLES = `PIN_BLANK_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Supply and thermal comparators
  input wire logic i_vcc_below_off,
  input wire logic i_vcc_above_on,
  input wire logic i_therm_above_upper,
  input wire logic i_therm_below_lower,
  // Other fault comparators
  input wire logic i_output_undervoltage,
  input wire logic i_latchoff_detect,
  input wire logic i_feedforward_low,
  input wire logic i_line_low_comparator,
  input wire logic i_erramp_charging,
  // Register bus
  input wire pfc_fault_supervisor_pkg::apb_req_t i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Supervisor outputs
  output logic o_power_good_out,
  output logic o_gate_enable,
  output logic o_control_ground,
  output logic o_hold_clamp_switch,
  output logic o_hysteresis_current,
  output logic o_shutdown,
  output logic o_line_fault_flag,
  output logic o_startup_phase,
  output logic o_thermal_upper_sel
);
  import pfc_fault_supervisor_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int BW = $clog2(BLANK_TICKS + WINDOW_TICKS + 1);
  localparam int PW = $clog2(PIN_BLANK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [BW-1:0] BLANK_LAST = BW'(BLANK_TICKS - 1);
  localparam logic [BW-1:0] WIN_LAST = BW'(WINDOW_TICKS - 1);
  localparam logic [PW-1:0] PIN_LAST = PW'(PIN_BLANK_CYCLES - 1);

  // Internal state
  logic lockout_q;       // Supply lockout latch
  logic thermal_q;       // Thermal shutdown state
  logic timing_open_q;   // Open timing pin latch
  logic startup_q;       // Start-up latch
  logic charging_q;      // Error amp charging, last cycle
  logic line_latch_q;    // Line-low latch
  logic tick_q;          // Slow tick pulse
  logic [TW-1:0] tick_cnt_q;
  logic [BW-1:0] bo_cnt_q;
  logic [PW-1:0] pin_cnt_q;
  bo_state_t bo_state_q;
  logic [1:0] ctrl_q;    // Run enable, pin latch clear pulse
  logic line_fault;
  logic major_fault;
  logic blank_end;
  logic win_end;
  logic bus_setup;
  logic bus_write;
  status_t status;

  // Line fault is the brown-out state itself
  assign line_fault = (bo_state_q == BO_FAULT);

  // Any condition that turns the stage off
  assign major_fault = lockout_q | thermal_q | timing_open_q |
                       i_output_undervoltage | i_latchoff_detect |
                       line_fault | ~ctrl_q[`CTRL_RUN_BIT];

  // Timer terminal conditions, only on a tick
  assign blank_end = (bo_state_q == BO_BLANK) && tick_q &&
                     (bo_cnt_q == BLANK_LAST);
  assign win_end = (bo_state_q == BO_WINDOW) && tick_q &&
                   (bo_cnt_q == WIN_LAST);

  // Bus phases
  assign bus_setup = i_apb.psel && !i_apb.penable;
  assign bus_write = i_apb.psel && i_apb.penable && o_pready &&
                     i_apb.pwrite;

  // Status word for readback
  assign status = '{
    startup_phase: startup_q,
    line_low_latch: line_latch_q,
    timing_pin_open: timing_open_q,
    thermal_shutdown: thermal_q,
    line_fault_flag: line_fault,
    supply_lockout: lockout_q,
    power_good: o_power_good_out
  };

  // Supply lockout hysteresis; reset counts as lockout
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      lockout_q <= 1'b1;
    else if (i_vcc_below_off)
      lockout_q <= 1'b1;         // Below off threshold
    else if (i_vcc_above_on)
      lockout_q <= 1'b0;         // Above on threshold
  end

  // Thermal hysteresis; reset picks the upper limit
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      thermal_q <= 1'b0;
    else if (i_therm_above_upper)
      thermal_q <= 1'b1;
    else if (i_therm_below_lower)
      thermal_q <= 1'b0;
  end

  // Open timing pin: blanked, then latched until lockout or the software clear pulse
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pin_cnt_q <= '0;
      timing_open_q <= 1'b0;
    end
    else
    begin
      // Short parasitic dips restart the count
      if (!i_feedforward_low)
        pin_cnt_q <= '0;
      else if (pin_cnt_q != PIN_LAST)
        pin_cnt_q <= pin_cnt_q + 1'b1;
      // Setting wins over a software clear in the same cycle
      if (i_feedforward_low && pin_cnt_q == PIN_LAST)
        timing_open_q <= 1'b1;
      else if (lockout_q || ctrl_q[`CTRL_PIN_CLR_BIT])
        timing_open_q <= 1'b0;
    end
  end

  // Start-up latch; set while off, clear on end of charging
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      startup_q <= 1'b1;
      charging_q <= 1'b0;
    end
    else
    begin
      charging_q <= i_erramp_charging;
      if (major_fault)
        startup_q <= 1'b1;
      else if (charging_q && !i_erramp_charging)
        startup_q <= 1'b0;
    end
  end

  // Slow tick divider shared by both line timers
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      // Free running; a timer may start mid-tick, so up to one tick early
      tick_q <= (tick_cnt_q == TICK_LAST);
      if (tick_cnt_q == TICK_LAST)
        tick_cnt_q <= '0;
      else
        tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // Brown-out qualifier: blanking, then detection window
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      bo_state_q <= BO_FAULT;
      bo_cnt_q <= '0;
      line_latch_q <= 1'b0;
    end
    else
    begin
      unique case (bo_state_q)
        BO_FAULT:
        begin
          // Timers held in reset while in fault
          bo_cnt_q <= '0;
          line_latch_q <= 1'b0;
          if (!lockout_q && !i_line_low_comparator)
            bo_state_q <= BO_IDLE;
        end
        BO_IDLE:
        begin
          bo_cnt_q <= '0;
          if (i_line_low_comparator)
          begin
            line_latch_q <= 1'b1;
            bo_state_q <= BO_BLANK;
          end
        end
        BO_BLANK:
        begin
          // No fault may be declared before blanking ends
          if (blank_end)
          begin
            bo_cnt_q <= '0;
            if (i_line_low_comparator)
              bo_state_q <= BO_FAULT;
            else
              bo_state_q <= BO_WINDOW;
          end
          else if (tick_q)
            bo_cnt_q <= bo_cnt_q + 1'b1;
        end
        BO_WINDOW:
        begin
          if (i_line_low_comparator)
            bo_state_q <= BO_FAULT;
          else if (win_end)
          begin
            bo_state_q <= BO_IDLE;
            bo_cnt_q <= '0;
            line_latch_q <= 1'b0;
          end
          else if (tick_q)
            bo_cnt_q <= bo_cnt_q + 1'b1;
        end
      endcase
    end
  end

  // Registered supervisor outputs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_power_good_out <= 1'b0;
      o_gate_enable <= 1'b0;
      o_control_ground <= 1'b1;
      o_hold_clamp_switch <= 1'b0;
      o_hysteresis_current <= 1'b0;
      o_shutdown <= 1'b0;
      o_line_fault_flag <= 1'b1;
      o_startup_phase <= 1'b1;
      o_thermal_upper_sel <= 1'b1;
    end
    else
    begin
      o_power_good_out <= !major_fault && !startup_q;
      o_gate_enable <= !major_fault;
      o_control_ground <= line_fault;
      // Clamp only outside fault, while the line is low
      o_hold_clamp_switch <= i_line_low_comparator &&
                             !line_fault;
      // Sink only once supply is up, until the line recovers
      o_hysteresis_current <= line_fault && !lockout_q;
      o_shutdown <= i_latchoff_detect;
      o_line_fault_flag <= line_fault;
      o_startup_phase <= startup_q;
      o_thermal_upper_sel <= !thermal_q;
    end
  end

  // Control register; clear bit is a self-clearing pulse
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ctrl_q <= `CTRL_RESET;
    else if (bus_write && i_apb.paddr == `ADDR_CTRL)
      ctrl_q <= i_apb.pwdata[1:0];
    else
      ctrl_q[`CTRL_PIN_CLR_BIT] <= 1'b0;
  end

  // APB slave: answer prepared in setup, shown in access
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end
    else if (bus_setup)
    begin
      o_pready <= 1'b1;
      unique case (i_apb.paddr)
        `ADDR_CTRL:
        begin
          o_prdata <= {31'h0, ctrl_q[`CTRL_RUN_BIT]};
          o_pslverr <= 1'b0;
        end
        `ADDR_STATUS:
        begin
          // Writes here are ignored without error
          o_prdata <= {25'h0, status};
          o_pslverr <= 1'b0;
        end
        default:
        begin
          // Unmapped: zero data and an error
          o_prdata <= 32'h0;
          o_pslverr <= 1'b1;
        end
      endcase
    end
    else
    begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end
  end

  // Checks on the supervisor behaviour
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence seq_line_drop;
    (bo_state_q == BO_IDLE) && i_line_low_comparator;
  endsequence
  sequence seq_window_clean;
    win_end && !i_line_low_comparator;
  endsequence

  AST_PG_LOCKOUT: assert property (
    lockout_q |=> !o_power_good_out)
    else $error("power good high during lockout");
  AST_PG_FAULTS: assert property (
    (thermal_q || i_output_undervoltage || line_fault || timing_open_q)
    |=> !o_power_good_out)
    else $error("power good high during fault");
  AST_SHUTDOWN: assert property (
    i_latchoff_detect |=> o_shutdown && !o_power_good_out && !o_gate_enable)
    else $error("latch-off did not shut down");
  AST_STARTUP_HOLD: assert property (
    startup_q |=> !o_power_good_out)
    else $error("power good during start-up");
  AST_STARTUP_END: assert property (
    (charging_q && !i_erramp_charging && !major_fault) |=> !startup_q ##1
    (o_power_good_out == !major_fault))
    else $error("start-up latch did not release");
  // Latch lands on the eighth low cycle, so seven clear ones follow the rise
  AST_PIN_BLANK: assert property (
    ($rose(i_feedforward_low) && !timing_open_q) |=> !timing_open_q[*7])
    else $error("timing pin fault not blanked");
  AST_CLAMP: assert property (
    (i_line_low_comparator && !line_fault) |=> o_hold_clamp_switch)
    else $error("hold clamp not enabled");
  AST_BLANK_START: assert property (
    seq_line_drop |=> (bo_state_q == BO_BLANK) && line_latch_q &&
    (bo_cnt_q == '0))
    else $error("blanking did not start");
  AST_NO_EARLY_FAULT: assert property (
    ((bo_state_q == BO_BLANK) && !blank_end) |=> !line_fault)
    else $error("fault declared during blanking");
  AST_WIN_FAULT: assert property (
    ((bo_state_q == BO_WINDOW) && i_line_low_comparator) |=> line_fault
    ##1 o_line_fault_flag)
    else $error("window fault missed");
  AST_WIN_CLEAN: assert property (
    seq_window_clean |=> (bo_state_q == BO_IDLE) && !line_latch_q &&
    (bo_cnt_q == '0))
    else $error("window end mishandled");
  AST_FAULT_OUTS: assert property (
    line_fault |=> !o_gate_enable && o_control_ground && !o_power_good_out)
    else $error("line fault outputs wrong");
  AST_FAULT_SINK: assert property (
    (line_fault && !lockout_q) |=> o_hysteresis_current &&
    !o_hold_clamp_switch)
    else $error("line fault sink or clamp wrong");
  AST_SINK_LOCKOUT: assert property (
    lockout_q |=> !o_hysteresis_current)
    else $error("sink on during lockout");
  AST_THERMAL: assert property (
    $rose(thermal_q) |=> !o_gate_enable && !o_thermal_upper_sel)
    else $error("thermal shutdown not applied");

endmodule : pfc_fault_supervisor

`default_nettype wire

// >>> pfc_downstream_model.sv
/*
  Behavioural model of the downstream converter fed by the power-good
  output. Assumes power good is a registered level on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pfc_downstream_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Enable from the supervisor
  input wire logic i_power_good,
  // Converter state
  output logic o_running
);
  logic running_q; // Converter switching

  // Runs only while enabled; one flop stands in for its start-up delay
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      running_q <= 1'b0;
    end
    else
    begin
      running_q <= i_power_good;
    end
  end

  assign o_running = running_q;
endmodule : pfc_downstream_model

`default_nettype wire

// >>> tb_top.sv
/*
  Self-checking bench for the fault supervisor: comparator levels, brown-out
  timing, timing pin fault and the APB registers.
  Assumes shortened tick and blanking parameters, one 8 ns clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pfc_fault_supervisor_consts.svh"

module tb_top;
  import pfc_fault_supervisor_pkg::*;
  localparam int TK = 4; // Short tick keeps the run brief
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic vbo = 1'b1, vab = 1'b0, thu = 1'b0, thl = 1'b1, uvolt = 1'b0;
  logic lof = 1'b0, ffl = 1'b0, llc = 1'b1, eac = 1'b0;
  apb_req_t bus = '0; // Register bus request
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, pg, gate, cgnd, clamp, sink, sdn, lff;
  logic sphase, tsel, running;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  pfc_fault_supervisor #(.TICK_CYCLES(TK), .BLANK_TICKS(5),
    .WINDOW_TICKS(3), .PIN_BLANK_CYCLES(8)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_vcc_below_off(vbo),
    .i_vcc_above_on(vab), .i_therm_above_upper(thu),
    .i_therm_below_lower(thl), .i_output_undervoltage(uvolt),
    .i_latchoff_detect(lof), .i_feedforward_low(ffl),
    .i_line_low_comparator(llc), .i_erramp_charging(eac), .i_apb(bus),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_power_good_out(pg), .o_gate_enable(gate), .o_control_ground(cgnd),
    .o_hold_clamp_switch(clamp), .o_hysteresis_current(sink),
    .o_shutdown(sdn), .o_line_fault_flag(lff), .o_startup_phase(sphase),
    .o_thermal_upper_sel(tsel));

  pfc_downstream_model partner (.i_clk(i_clk), .i_rst(i_rst),
    .i_power_good(pg), .o_running(running));

  // Free-running clock, 125 MHz
  always #4 i_clk = ~i_clk;

  // Compare one value and count it
  task automatic check(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick

  // One APB transfer; holds the request until pready is sampled
  task automatic apb_xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] wd);
    int n;
    @(posedge i_clk);
    bus.psel <= 1'b1;
    bus.penable <= 1'b0;
    bus.pwrite <= wr;
    bus.paddr <= a;
    bus.pwdata <= wd;
    @(posedge i_clk);
    bus.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (pready !== 1'b1);
    // Only the global timeout ends a stuck wait; the slave answers at once
    check("pready_wait", 1, n == 1);
    rd = prdata;
    err = pslverr;
    bus.psel <= 1'b0;
    bus.penable <= 1'b0;
  endtask : apb_xfer

  // Error amp stops charging; start-up ends, power good returns
  task automatic recover();
    eac <= 1'b1;
    tick(3);
    eac <= 1'b0;
    tick(4);
    check("pg_up", 1, pg);
    check("running", 1, running);
  endtask : recover

  // Lockout lifts with line still low, then line recovers
  task automatic t_bringup();
    check("pg_rst", 0, pg);
    check("lff_rst", 1, lff);
    check("tsel_rst", 1, tsel);
    check("sphase_rst", 1, sphase);
    tick(2);
    vbo <= 1'b0;
    vab <= 1'b1;
    tick(4);
    check("sink_on", 1, sink);
    check("cgnd", 1, cgnd);
    check("gate_off", 0, gate);
    llc <= 1'b0;
    tick(4);
    check("lff_clr", 0, lff);
    check("sink_off", 0, sink);
    check("pg_start", 0, pg);
    recover();
    check("gate_on", 1, gate);
    $display("test bringup done");
  endtask : t_bringup

  // Undervoltage and latch-off each drop power good
  task automatic t_faults();
    for (int i = 0; i < 2; i++)
    begin
      if (i == 0)
        uvolt <= 1'b1;
      else
        lof <= 1'b1;
      tick(3);
      check("pg_fault", 0, pg);
      check("shutdown", i, sdn);
      uvolt <= 1'b0;
      lof <= 1'b0;
      tick(3);
      check("sphase_again", 1, sphase);
      recover();
    end
    $display("test faults done");
  endtask : t_faults

  // Shut down above upper limit, stay off until below lower
  task automatic t_thermal();
    thu <= 1'b1;
    thl <= 1'b0;
    tick(3);
    check("pg_therm", 0, pg);
    check("tsel_low", 0, tsel);
    thu <= 1'b0;
    tick(6);
    check("therm_hold", 0, gate);
    thl <= 1'b1;
    tick(3);
    recover();
    $display("test thermal done");
  endtask : t_thermal

  // Short line dip rides through blanking and window
  task automatic t_brown_short();
    llc <= 1'b1;
    tick(2);
    llc <= 1'b0;
    tick(1);
    check("clamp_on", 1, clamp);
    tick(40);
    check("pg_ride", 1, pg);
    apb_xfer(1'b0, `ADDR_STATUS, 32'h0);
    check("latch_clr", 32'h0, rd & 32'h24);
    $display("test brown short done");
  endtask : t_brown_short

  // Held dip faults after blanking; late dip faults inside window
  task automatic t_brown_fault();
    for (int i = 0; i < 2; i++)
    begin
      llc <= 1'b1;
      tick(i == 0 ? 12 : 2);
      check("blank_pg", 1, pg);
      if (i == 1)
      begin
        llc <= 1'b0;
        tick(20);
        llc <= 1'b1;
      end
      tick(18);
      check("lff_set", 1, lff);
      check("pg_bo", 0, pg);
      check("clamp_off", 0, clamp);
      check("sink_bo", 1, sink);
      check("cgnd_bo", 1, cgnd);
      llc <= 1'b0;
      tick(4);
      recover();
    end
    $display("test brown fault done");
  endtask : t_brown_fault

  // Timing pin glitch ignored; long one latches until lockout
  task automatic t_pin();
    ffl <= 1'b1;
    tick(5);
    ffl <= 1'b0;
    tick(3);
    check("pin_blank", 1, pg);
    ffl <= 1'b1;
    tick(14);
    ffl <= 1'b0;
    tick(4);
    check("pin_latch", 0, pg);
    vbo <= 1'b1;
    tick(3);
    apb_xfer(1'b0, `ADDR_STATUS, 32'h0);
    check("lockout", 32'h2, rd & 32'h3);
    vbo <= 1'b0;
    tick(4);
    apb_xfer(1'b0, `ADDR_STATUS, 32'h0);
    check("pin_clr", 32'h0, rd & 32'h10);
    // Latch again, then drop it with the software clear pulse
    ffl <= 1'b1;
    tick(10);
    ffl <= 1'b0;
    apb_xfer(1'b0, `ADDR_STATUS, 32'h0);
    check("pin_set", 32'h10, rd & 32'h10);
    apb_xfer(1'b1, `ADDR_CTRL, 32'h3);
    apb_xfer(1'b0, `ADDR_STATUS, 32'h0);
    check("pin_swclr", 32'h0, rd & 32'h10);
    recover();
    $display("test pin done");
  endtask : t_pin

  // Run bit off is a fault; unmapped address is refused
  task automatic t_regs();
    apb_xfer(1'b0, `ADDR_CTRL, 32'h0);
    check("ctrl_rst", 32'h1, rd);
    check("slverr_ok", 0, err);
    apb_xfer(1'b1, `ADDR_CTRL, 32'h0);
    tick(3);
    check("pg_run0", 0, pg);
    apb_xfer(1'b1, 12'h008, 32'h1);
    check("slverr", 1, err);
    // Refused write must leave the control word alone
    apb_xfer(1'b0, `ADDR_CTRL, 32'h0);
    check("ctrl_kept", 32'h0, rd);
    apb_xfer(1'b1, `ADDR_CTRL, 32'h1);
    tick(3);
    recover();
    $display("test regs done");
  endtask : t_regs

  // Hang guard: ceiling well above the expected run
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      errors++;
      results();
    end
  end

  // Main sequence
  initial
  begin
    tick(4);
    i_rst <= 1'b0;
    tick(1);
    t_bringup();
    t_faults();
    t_thermal();
    t_brown_short();
    t_brown_fault();
    t_pin();
    t_regs();
    results();
  end
endmodule : tb_top

`default_nettype wire
